// >>> src/cond_seq_top.sv
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module cond_seq_top
  import cond_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [15:0] storage_addr,
  output logic [7:0] cond_flags,
  output logic busy
);
  import cond_flags_pkg::*;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC, S_DONE} seq_t;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[i*8 +: 8] = d[i*8 +: 8];
    return m;
  endfunction

  logic [7:0] cond_r, cond_nxt;
  logic [15:0] insn_addr_r, insn_addr_nxt;
  logic [15:0] index_one_r, index_one_nxt;
  logic [15:0] index_two_r, index_two_nxt;
  logic [15:0] oper_ptr_r, oper_ptr_nxt;
  logic [15:0] store_addr_r, store_addr_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] data_r, data_nxt;
  logic [2:0] left_r, left_nxt;
  logic [2:0] bytes_r, bytes_nxt;
  seq_t state_r, state_nxt;
  logic [31:0] readdata_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] flag_out;
  logic [15:0] eff_addr;
  logic [16:0] sum;
  logic [15:0] diff;
  logic [15:0] res;
  logic [15:0] shr;
  logic ovf;
  op_t op;
  logic is_wr, is_rd;

  // data register holds operand one low half, operand two high half
  assign op = op_t'(ctrl_r[C_OP_HI:C_OP_LO]);
  assign is_wr = write && ack_r;
  assign is_rd = read && !ack_r;

  always_comb
  begin
    sum = {1'b0, data_r[15:0]} + {1'b0, data_r[31:16]};
    diff = 16'(data_r[15:0] - data_r[31:16]);
    shr = {1'b0, data_r[15:1]};
    ovf = (data_r[15] == data_r[31]) && (sum[15] != data_r[15]);
    case (op)
      OP_ZAZ: res = data_r[31:16];
      OP_AZSZ: res = ctrl_r[C_ITC] ? diff : sum[15:0];
      OP_EDIT: res = data_r[31:16];
      OP_ADDL: res = sum[15:0];
      OP_SHR: res = shr;
      default: res = diff;
    endcase
  end

  flag_calc u_flags (
    .op(ctrl_r[C_OP_HI:C_OP_LO]),
    .cond_in(cond_r),
    .res(res),
    .opnd_a(data_r[15:0]),
    .opnd_b(data_r[31:16]),
    .imm(ctrl_r[C_IMM_HI:C_IMM_LO]),
    .carry(sum[16]),
    .ovf(ovf),
    .shifted_one(data_r[0]),
    .insn_word(data_r[15:0]),
    .cond_out(flag_out)
  );

  addr_gen u_addr (
    .indexed(ctrl_r[C_INDEXED]),
    .xsel(ctrl_r[C_XSEL]),
    .direct_addr(data_r[15:0]),
    .disp(ctrl_r[C_DISP_HI:C_DISP_LO]),
    .index_one(index_one_r),
    .index_two(index_two_r),
    .eff_addr(eff_addr)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    cond_nxt = cond_r;
    insn_addr_nxt = insn_addr_r;
    index_one_nxt = index_one_r;
    index_two_nxt = index_two_r;
    oper_ptr_nxt = oper_ptr_r;
    store_addr_nxt = store_addr_r;
    ctrl_nxt = ctrl_r;
    data_nxt = data_r;
    left_nxt = left_r;
    bytes_nxt = bytes_r;
    state_nxt = state_r;
    readdata_nxt = 32'h0000_0000;
    ack_nxt = 1'b0;
    // one wait cycle per access; a write lands only at the edge that sees the answer
    if ((read || write) && !ack_r)
      ack_nxt = 1'b1;
    if (is_rd)
      case (address)
        ADDR_COND: readdata_nxt = {24'h000000, cond_r};
        ADDR_INSN_ADDR: readdata_nxt = {16'h0000, insn_addr_r};
        ADDR_INDEX_ONE: readdata_nxt = {16'h0000, index_one_r};
        ADDR_INDEX_TWO: readdata_nxt = {16'h0000, index_two_r};
        ADDR_OPER_PTR: readdata_nxt = {16'h0000, oper_ptr_r};
        ADDR_STORE_ADDR: readdata_nxt = {16'h0000, store_addr_r};
        ADDR_STATUS: readdata_nxt = {29'h0000_0000, left_r};
        ADDR_CTRL: readdata_nxt = ctrl_r;
        ADDR_DATA: readdata_nxt = data_r;
        default: readdata_nxt = 32'h0000_0000;
      endcase
    case (state_r)
      S_IDLE:
        if (ctrl_r[C_GO])
        begin
          left_nxt = ctrl_r[C_LEN_HI:C_LEN_LO];
          bytes_nxt = 3'h0;
          state_nxt = S_FETCH;
        end
      S_FETCH:
        if (left_r == 3'h0)
          state_nxt = S_EXEC; // see [RL22]
        else if (ctrl_r[C_WIDE] && left_r > 3'h1)
        begin
          insn_addr_nxt = 16'(insn_addr_r + 16'h0002); // see [RL21]
          left_nxt = 3'(left_r - 3'h2);
        end
        else
        begin
          insn_addr_nxt = 16'(insn_addr_r + 16'h0001); // see [RL21]
          left_nxt = 3'(left_r - 3'h1);
        end
      S_EXEC:
      begin
        cond_nxt = flag_out; // see [RL2]
        if (op == OP_BRANCH)
        begin
          // control immediate field is the mask; taken when any masked condition bit is set
          if (ctrl_r[C_IMM_LO + B_TEST])
            cond_nxt[B_TEST] = 1'b0; // see [RL13]
          if (ctrl_r[C_IMM_LO + B_OVF])
            cond_nxt[B_OVF] = 1'b0; // see [RL13]
          if ((cond_r & ctrl_r[C_IMM_HI:C_IMM_LO]) != 8'h00)
            insn_addr_nxt = eff_addr; // see [RL23]
        end
        else
        begin
          store_addr_nxt = eff_addr; // see [RL18]
          if (ctrl_r[C_INDEXED])
            oper_ptr_nxt = eff_addr; // see [RL19]
          else
            oper_ptr_nxt = data_r[15:0];
        end
        state_nxt = S_DONE;
      end
      S_DONE:
      begin
        ctrl_nxt[C_GO] = 1'b0;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    if (is_wr)
      case (address)
        ADDR_COND: if (byteenable[0]) cond_nxt = writedata[7:0]; // see [RL2]
        ADDR_INSN_ADDR:
          insn_addr_nxt = 16'(merge({16'h0000, insn_addr_r}, writedata, byteenable));
        ADDR_INDEX_ONE:
          index_one_nxt = 16'(merge({16'h0000, index_one_r}, writedata, byteenable));
        ADDR_INDEX_TWO:
          index_two_nxt = 16'(merge({16'h0000, index_two_r}, writedata, byteenable));
        ADDR_STORE_ADDR:
          // pulse: C_ITC clear in data and control steps operand pointer down, C_ITC set in either steps it up for insert-and-test
          if (writedata[C_ITC] || ctrl_r[C_ITC])
            oper_ptr_nxt = 16'(oper_ptr_r + 16'h0001); // see [RL17]
          else
            oper_ptr_nxt = 16'(oper_ptr_r - 16'h0001); // see [RL16]
        ADDR_CTRL:
          if (state_r == S_IDLE)
            ctrl_nxt = merge(ctrl_r, writedata, byteenable);
        ADDR_DATA: data_nxt = merge(data_r, writedata, byteenable);
        default: ;
      endcase
    if (is_wr && address == ADDR_CTRL && writedata[C_PROC_RESET] && byteenable[0])
    begin
      cond_nxt = COND_RESET; // see [RL15]
      ctrl_nxt = 32'h0000_0000;
      state_nxt = S_IDLE;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cond_r <= COND_RESET; // see [RL15] see [RL1]
      insn_addr_r <= 16'h0000;
      index_one_r <= 16'h0000;
      index_two_r <= 16'h0000;
      oper_ptr_r <= 16'h0000;
      store_addr_r <= 16'h0000;
      ctrl_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      left_r <= 3'h0;
      bytes_r <= 3'h0;
      state_r <= S_IDLE;
      readdata <= 32'h0000_0000;
      ack_r <= 1'b0;
    end
    else
    begin
      cond_r <= cond_nxt;
      insn_addr_r <= insn_addr_nxt;
      index_one_r <= index_one_nxt;
      index_two_r <= index_two_nxt;
      oper_ptr_r <= oper_ptr_nxt;
      store_addr_r <= store_addr_nxt;
      ctrl_r <= ctrl_nxt;
      data_r <= data_nxt;
      left_r <= left_nxt;
      bytes_r <= bytes_nxt;
      state_r <= state_nxt;
      readdata <= readdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      storage_addr <= 16'h0000;
      cond_flags <= COND_RESET;
      busy <= 1'b0;
    end
    else
    begin
      waitrequest <= !((read || write) && !ack_r && !ack_nxt) && !ack_nxt;
      storage_addr <= store_addr_nxt;
      cond_flags <= cond_nxt;
      busy <= state_nxt != S_IDLE;
    end
  end
endmodule

// >>> pkg/cond_flags_pkg.sv
// Functional notes
// [RL1] eight-bit condition register tested by branches
// [RL2] register changes only on listed events
// [RL3] zero-and-add zoned sets bits 7/6/5
// [RL4] zoned add/sub adds overflow on bit 4
// [RL5] edit reports operand two zero/neg/pos
// [RL6] edit flags only on qualifying conditions
// [RL7] compare/subtract characters: equal, low, high
// [RL8] compare immediate: equal, low, high
// [RL9] add logical/register: zero, nocarry, carry, bit2
// [RL10] subtract from register: zero, below, above
// [RL11] test bits set bit 3 on mismatch
// [RL12] shift right: zero, even, odd, bit2
// [RL13] branch or jump clears tested bit
// [RL14] register load decodes instruction bits 10-15
// [RL15] resets load condition register with 01
// [RL16] operand pointer decrements per byte
// [RL17] insert-and-test increments operand pointer
// [RL18] direct address loads storage latch unchanged
// [RL19] indexed address is index plus displacement
// [RL20] instruction selects index register one or two
// [RL21] fetch advances address by one or two
// [RL22] execute only after all bytes fetched
// [RL23] taken branch loads target into address
// [RL24] undefined bits keep previous values; register load (OP_LOADCR) clears bits 1 and 0
package cond_flags_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_COND = 4'h0;
  localparam logic [3:0] ADDR_INSN_ADDR = 4'h1;
  localparam logic [3:0] ADDR_INDEX_ONE = 4'h2;
  localparam logic [3:0] ADDR_INDEX_TWO = 4'h3;
  localparam logic [3:0] ADDR_OPER_PTR = 4'h4;
  localparam logic [3:0] ADDR_STORE_ADDR = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_CTRL = 4'h7;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [7:0] COND_RESET = 8'h01;
  localparam logic [7:0] EDIT_FILL = 8'h20;
  // ****************************************
  // condition bit positions
  // ****************************************
  localparam int B_ZERO = 7;
  localparam int B_NEG = 6;
  localparam int B_POS = 5;
  localparam int B_OVF = 4;
  localparam int B_TEST = 3;
  localparam int B_CARRY = 2;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int C_OP_LO = 0;
  localparam int C_OP_HI = 3;
  localparam int C_GO = 4;
  localparam int C_PROC_RESET = 5;
  localparam int C_WIDE = 6;
  localparam int C_INDEXED = 7;
  localparam int C_XSEL = 8;
  localparam int C_ITC = 9;
  localparam int C_LEN_LO = 10;
  localparam int C_LEN_HI = 12;
  localparam int C_DISP_LO = 16;
  localparam int C_DISP_HI = 23;
  localparam int C_IMM_LO = 24;
  localparam int C_IMM_HI = 31;
  // ****************************************
  // operation codes of the control register
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE, OP_ZAZ, OP_AZSZ, OP_EDIT, OP_CMPC, OP_CMPI, OP_ADDL, OP_SUBR,
    OP_TBON, OP_TBOF, OP_SHR, OP_BRANCH, OP_LOADCR, OP_ADDR_ONLY
  } op_t;
endpackage

// >>> src/flag_calc.sv
`timescale 1ns/1ns
module flag_calc
  import cond_flags_pkg::*;
(
  input wire logic [3:0] op,
  input wire logic [7:0] cond_in,
  input wire logic [15:0] res,
  input wire logic [15:0] opnd_a,
  input wire logic [15:0] opnd_b,
  input wire logic [7:0] imm,
  input wire logic carry,
  input wire logic ovf,
  input wire logic shifted_one,
  input wire logic [15:0] insn_word,
  output logic [7:0] cond_out
);
  function automatic logic [7:0] tri_set(input logic [7:0] c, input logic z,
    input logic n, input logic p);
    logic [7:0] t;
    t = c;
    t[B_ZERO] = z;
    t[B_NEG] = n;
    t[B_POS] = p;
    return t;
  endfunction

  logic zr;
  logic edit_ok;
  always_comb
  begin
    zr = (res == 16'h0000);
    edit_ok = !zr || cond_in[B_ZERO] || (opnd_a[7:0] == EDIT_FILL); // see [RL6]
    cond_out = cond_in; // see [RL24]
    case (op)
      OP_ZAZ: cond_out = tri_set(cond_in, zr, !zr && res[15], !zr && !res[15]); // see [RL3]
      OP_AZSZ:
      begin
        cond_out = tri_set(cond_in, zr, !zr && res[15], !zr && !res[15]); // see [RL4]
        cond_out[B_OVF] = ovf ? 1'b1 : cond_in[B_OVF];
      end
      OP_EDIT:
        if (edit_ok)
          cond_out = tri_set(cond_in, zr, !zr && res[15], !zr && !res[15]); // see [RL5]
      OP_CMPC, OP_SUBR:
        cond_out = tri_set(cond_in, opnd_a == opnd_b, opnd_a < opnd_b,
          opnd_a > opnd_b); // see [RL7] see [RL10]
      OP_CMPI:
        cond_out = tri_set(cond_in, opnd_a[7:0] == imm, opnd_a[7:0] < imm,
          opnd_a[7:0] > imm); // see [RL8]
      OP_ADDL:
      begin
        cond_out = tri_set(cond_in, zr, !zr && !carry, !zr && carry); // see [RL9]
        cond_out[B_CARRY] = carry;
      end
      OP_TBON: cond_out[B_TEST] = (opnd_a[7:0] & imm) != imm; // see [RL11]
      OP_TBOF: cond_out[B_TEST] = (opnd_a[7:0] & imm) != 8'h00; // see [RL11]
      OP_SHR:
      begin
        cond_out = tri_set(cond_in, zr, !zr && !res[0], res[0]); // see [RL12]
        cond_out[B_CARRY] = shifted_one;
      end
      OP_LOADCR:
      begin
        cond_out = 8'h00; // see [RL14]
        cond_out[B_ZERO] = insn_word[15];
        cond_out[B_NEG] = !insn_word[15] && insn_word[14];
        cond_out[B_POS] = !insn_word[15] && !insn_word[14];
        cond_out[B_OVF] = insn_word[12];
        cond_out[B_TEST] = insn_word[11];
        cond_out[B_CARRY] = insn_word[10];
      end
      default: cond_out = cond_in;
    endcase
  end
endmodule

// >>> src/addr_gen.sv
`timescale 1ns/1ns
module addr_gen
(
  input wire logic indexed,
  input wire logic xsel,
  input wire logic [15:0] direct_addr,
  input wire logic [7:0] disp,
  input wire logic [15:0] index_one,
  input wire logic [15:0] index_two,
  output logic [15:0] eff_addr
);
  logic [15:0] base;
  always_comb
  begin
    base = xsel ? index_two : index_one; // see [RL20]
    eff_addr = indexed ? 16'(base + {8'h00, disp}) : direct_addr; // see [RL19] see [RL18]
  end
endmodule

// >>> bench/cond_seq_asserts.sv
`timescale 1ns/1ns
module cond_seq_asserts
  import cond_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [15:0] storage_addr,
  input wire logic [7:0] cond_flags,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // bus handshake
  // ****************************************
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_rd_ack;
    read && !waitrequest;
  endsequence
  property p_ack_once;
    !waitrequest |=> waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_bound;
    s_req |-> ##[1:2] !waitrequest;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("request not answered");
  property p_ack_cause;
    $fell(waitrequest) |-> $past(read || write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    s_rd_ack and (address > 4'h8) |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ****************************************
  // condition register and sequencer
  // ****************************************
  property p_cond_reset;
    $rose(rst_n) |-> cond_flags == COND_RESET;
  endproperty
  a_cond_reset: assert property (p_cond_reset) else $error("bad reset flags");
  property p_cond_only;
    $changed(cond_flags) |-> $past(busy) || $past(write && !waitrequest);
  endproperty
  a_cond_only: assert property (p_cond_only) else $error("flags changed unasked");
  property p_cond_read;
    s_rd_ack and (address == ADDR_COND) |-> readdata == {24'h0, cond_flags};
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("flag readback wrong");
  property p_busy_cause;
    $rose(busy) |-> $past(write && !waitrequest && address == ADDR_CTRL, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_addr_quiet;
    $changed(storage_addr) |-> $past(busy) || $past(write && !waitrequest);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address moved unasked");
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
  import cond_flags_pkg::*;
  logic clk, rst_n, read, write, waitrequest, busy;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [15:0] storage_addr;
  logic [7:0] cond_flags;
  int fails = 0;
  int checked = 0;
  cond_seq_top dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .storage_addr(storage_addr), .cond_flags(cond_flags),
    .busy(busy));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // starts one edge later so a release and a new request never share a time step
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
      chk("bus answer", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b0, a, d, 4'hF, r);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b1, a, 32'h0, 4'hF, r);
  endtask
  function automatic logic [31:0] cw(input logic [3:0] op, input logic [3:0] md,
                                     input logic [2:0] ln, input logic [7:0] dp,
                                     input logic [7:0] im);
    return {im, dp, 3'h0, ln, md, 1'b0, 1'b1, op};
  endfunction
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    wr(ADDR_CTRL, c);
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
      chk("busy end", 32'h0, 32'h1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("flags port", 32'h01, {24'h0, cond_flags});
    rd(ADDR_COND, q);
    chk("cond", 32'h01, q);
    rd(4'h9, q);
    chk("unmapped", 32'h0, q);
    wr(ADDR_COND, 32'h5A);
    bus(1'b0, ADDR_COND, 32'hFF, 4'h0, q);
    rd(ADDR_COND, q);
    chk("cond load", 32'h5A, q);
    wr(ADDR_CTRL, 32'h20);
    rd(ADDR_COND, q);
    chk("proc reset", 32'h01, q);
    // system reset in mid-run, with no request in flight
    wr(ADDR_COND, 32'h5A);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("flags in reset", 32'h01, {24'h0, cond_flags});
    rd(ADDR_COND, q);
    chk("sys reset", 32'h01, q);
    $display("reset test done");
  endtask
  // preset shows which bits an operation leaves alone
  task automatic flag_exp(input logic [3:0] op, input logic [3:0] md, input logic [31:0] d,
                          input logic [7:0] im, input logic [7:0] pre, input logic [7:0] f);
    wr(ADDR_COND, {24'h0, pre});
    wr(ADDR_DATA, d);
    run(cw(op, md, 3'h3, 8'h00, im));
    rd(ADDR_COND, q);
    chk("cond flags", {24'h0, f}, q);
  endtask
  // bits 4..2 preset so that untouched bits are seen to survive
  task automatic flag_case(input logic [3:0] op, input logic [31:0] d, input logic [7:0] im,
                           input logic [7:0] f);
    flag_exp(op, 4'h0, d, im, 8'h1C, 8'h1C | f);
  endtask
  task automatic t_compare();
    flag_case(OP_CMPC, 32'h0042_0042, 8'h00, 8'h80);
    flag_case(OP_CMPC, 32'h0043_0042, 8'h00, 8'h40);
    flag_case(OP_CMPC, 32'h0041_0042, 8'h00, 8'h20);
    flag_case(OP_CMPI, 32'h0000_0037, 8'h37, 8'h80);
    flag_case(OP_CMPI, 32'h0000_0036, 8'h37, 8'h40);
    flag_case(OP_CMPI, 32'h0000_0038, 8'h37, 8'h20);
    $display("compare test done");
  endtask
  task automatic t_arith();
    flag_exp(OP_ZAZ, 4'h0, 32'h8001_0000, 8'h00, 8'h1C, 8'h5C);
    flag_exp(OP_ZAZ, 4'h0, 32'h0000_1234, 8'h00, 8'h1C, 8'h9C);
    flag_exp(OP_AZSZ, 4'h0, 32'h4000_4000, 8'h00, 8'h00, 8'h50);
    flag_exp(OP_AZSZ, 4'h8, 32'h0001_0003, 8'h00, 8'h00, 8'h20);
    flag_exp(OP_EDIT, 4'h0, 32'h0000_0000, 8'h00, 8'h1C, 8'h1C);
    flag_exp(OP_EDIT, 4'h0, 32'h0000_0020, 8'h00, 8'h1C, 8'h9C);
    flag_exp(OP_EDIT, 4'h0, 32'hFFFF_0000, 8'h00, 8'h1C, 8'h5C);
    flag_exp(OP_EDIT, 4'h0, 32'h0012_0000, 8'h00, 8'h1C, 8'h3C);
    flag_exp(OP_ADDL, 4'h0, 32'h0001_0001, 8'h00, 8'h1C, 8'h58);
    flag_exp(OP_ADDL, 4'h0, 32'hFFFF_0001, 8'h00, 8'h00, 8'h84);
    flag_exp(OP_ADDL, 4'h0, 32'hFFFF_0002, 8'h00, 8'h00, 8'h24);
    flag_exp(OP_SUBR, 4'h0, 32'h0005_0003, 8'h00, 8'h1C, 8'h5C);
    flag_exp(OP_SUBR, 4'h0, 32'h0003_0005, 8'h00, 8'h1C, 8'h3C);
    flag_exp(OP_TBON, 4'h0, 32'h0000_0007, 8'h0F, 8'h00, 8'h08);
    flag_exp(OP_TBON, 4'h0, 32'h0000_001F, 8'h0F, 8'h00, 8'h00);
    flag_exp(OP_TBOF, 4'h0, 32'h0000_0010, 8'h30, 8'h00, 8'h08);
    flag_exp(OP_TBOF, 4'h0, 32'h0000_0040, 8'h30, 8'h00, 8'h00);
    flag_exp(OP_SHR, 4'h0, 32'h0000_0005, 8'h00, 8'h00, 8'h44);
    flag_exp(OP_SHR, 4'h0, 32'h0000_0006, 8'h00, 8'h1C, 8'h38);
    flag_exp(OP_SHR, 4'h0, 32'h0000_0001, 8'h00, 8'h00, 8'h84);
    $display("arithmetic test done");
  endtask
  task automatic load_case(input logic [31:0] d, input logic [7:0] f);
    wr(ADDR_DATA, d);
    run(cw(OP_LOADCR, 4'h0, 3'h3, 8'h00, 8'h00));
    rd(ADDR_COND, q);
    chk("loaded flags", {24'h0, f}, q & 32'hFC);
  endtask
  task automatic t_load_branch();
    load_case(32'h0000_C000, 8'h80);
    load_case(32'h0000_4000, 8'h40);
    load_case(32'h0000_1C00, 8'h3C);
    wr(ADDR_DATA, 32'h0000_0200);
    wr(ADDR_INSN_ADDR, 32'h0100);
    wr(ADDR_COND, 32'h18);
    run(cw(OP_BRANCH, 4'h0, 3'h3, 8'h00, 8'h08));
    rd(ADDR_COND, q);
    chk("tested bit", 32'h10, q);
    rd(ADDR_INSN_ADDR, q);
    chk("branch target", 32'h0200, q);
    run(cw(OP_BRANCH, 4'h0, 3'h3, 8'h00, 8'h08));
    rd(ADDR_INSN_ADDR, q);
    chk("not taken", 32'h0203, q);
    run(cw(OP_BRANCH, 4'h0, 3'h3, 8'h00, 8'h10));
    rd(ADDR_COND, q);
    chk("tested overflow", 32'h00, q);
    $display("load and branch test done");
  endtask
  task automatic t_fetch();
    wr(ADDR_INSN_ADDR, 32'h0100);
    run(cw(OP_NONE, 4'h0, 3'h3, 8'h00, 8'h00));
    rd(ADDR_INSN_ADDR, q);
    chk("insn addr", 32'h0103, q);
    run(cw(OP_NONE, 4'h1, 3'h4, 8'h00, 8'h00));
    rd(ADDR_INSN_ADDR, q);
    chk("insn addr wide", 32'h0107, q);
    $display("fetch test done");
  endtask
  task automatic t_index();
    wr(ADDR_INDEX_ONE, 32'h1000);
    wr(ADDR_INDEX_TWO, 32'h2000);
    run(cw(OP_ADDR_ONLY, 4'h2, 3'h3, 8'h34, 8'h00));
    chk("store addr", 32'h1034, {16'h0, storage_addr});
    run(cw(OP_ADDR_ONLY, 4'h6, 3'h3, 8'h34, 8'h00));
    chk("store addr two", 32'h2034, {16'h0, storage_addr});
    rd(ADDR_OPER_PTR, q);
    chk("oper ptr", 32'h2034, q);
    wr(ADDR_STORE_ADDR, 32'h0);
    rd(ADDR_OPER_PTR, q);
    chk("ptr down", 32'h2033, q);
    wr(ADDR_STORE_ADDR, 32'h200);
    rd(ADDR_OPER_PTR, q);
    chk("ptr up", 32'h2034, q);
    wr(ADDR_DATA, 32'h0000_4321);
    run(cw(OP_ADDR_ONLY, 4'h0, 3'h3, 8'h34, 8'h00));
    chk("store addr direct", 32'h4321, {16'h0, storage_addr});
    $display("index test done");
  endtask
  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_compare();
    t_arith();
    t_load_branch();
    t_fetch();
    t_index();
    complete_run();
  end
  // well beyond the 148 accesses of the run
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end
endmodule
bind cond_seq_top cond_seq_asserts u_chk (.clk(clk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .storage_addr(storage_addr),
  .cond_flags(cond_flags), .busy(busy));
